// ==== i2c_codec_pkg.sv ====
// shared constants, types and helpers for the codec control port link
package i2c_codec_pkg;

    // ==========================================================
    // slave address and register map shape
    localparam logic [4:0] SLAVE_PREFIX   = 5'h04;   // fixed upper address bits 00100
    localparam logic [1:0] RXTX_BANK_SEL  = 2'h0;    // select value of the receiver/transmitter bank
    localparam int         ADDR_W         = 5;       // register address width
    localparam int         DATA_W         = 8;       // control data width
    localparam int         REG_CNT        = 32;      // registers per bank
    localparam logic [3:0] BYTE_BITS      = 4'h8;    // data bits per byte, ack follows
    localparam logic [3:0] LAST_BIT       = 4'h7;    // bit count when a byte completes
    localparam logic [4:0] PTR_RESET      = 5'h00;   // address counter after reset
    localparam logic [7:0] REG_RESET      = 8'h00;   // register contents after reset

    // ==========================================================
    // timing
    localparam int CLK_PERIOD_NS = 100;              // system clock period
    localparam int SCL_PERIOD_NS = 10000;            // shortest link clock period, 100 kHz
    localparam int QTR_CYC       = (SCL_PERIOD_NS + 4 * CLK_PERIOD_NS - 1) / (4 * CLK_PERIOD_NS);
    localparam logic [4:0] QTR_LAST = 5'(QTR_CYC - 1);
    localparam int SCL_HI_MIN    = 39;               // system cycles of a legal clock high phase, less one
    localparam int SCL_LO_MIN    = 46;               // system cycles of a legal clock low phase, less one

    // ==========================================================
    // host byte-level operations
    typedef enum logic [3:0] {
        OP_START = 4'h1,
        OP_WRITE = 4'h2,
        OP_READ  = 4'h4,
        OP_STOP  = 4'h8
    } op_t;

    // device link states
    typedef enum logic [4:0] {
        D_IDLE  = 5'h01,
        D_SLAVE = 5'h02,
        D_REGA  = 5'h04,
        D_WDATA = 5'h08,
        D_RDATA = 5'h10
    } dev_state_t;

    // host sequencer states
    typedef enum logic [3:0] {
        M_IDLE  = 4'h1,
        M_START = 4'h2,
        M_BIT   = 4'h4,
        M_STOP  = 4'h8
    } host_state_t;

    // address counter step, rolls 1F over to 00
    function automatic logic [ADDR_W-1:0] next_ptr(input logic [ADDR_W-1:0] p);
        next_ptr = p + 5'h01;
    endfunction

endpackage

// ==== i2c_codec_link_if.sv ====
// two-wire link between the host end and the codec control port
`timescale 1ns/1ps
interface i2c_codec_link_if;
    logic scl;        // link clock, driven by the host
    logic m_sda_out;  // host data output level (always low)
    logic m_sda_oe;   // host pulls data low
    logic s_sda_out;  // device data output level (always low)
    logic s_sda_oe;   // device pulls data low
    logic sda;        // resolved wired-and data line

    // open-drain resolution with pull-up
    assign sda = ~((m_sda_oe & ~m_sda_out) | (s_sda_oe & ~s_sda_out));

    modport host   (output scl, m_sda_out, m_sda_oe, input sda);
    modport device (input scl, sda, output s_sda_out, s_sda_oe);
endinterface

// ==== i2c_codec_device.sv ====
// codec control port: slave end of the two-wire link with write hand-off
`timescale 1ns/1ps
module i2c_codec_device
    import i2c_codec_pkg::*;
(
    input  wire logic                  SYS_CLK_IN,          // system clock, 10 MHz
    input  wire logic                  RESET_N_IN,          // power-down reset, active low
    i2c_codec_link_if.device           LINK_IF,             // two-wire link
    input  wire logic                  ADDR_SELECT_PIN_HI_IN, // upper select strap
    input  wire logic                  ADDR_SELECT_PIN_LO_IN, // lower select strap
    output logic                       WR_STB_OUT,          // one-cycle write strobe
    output logic                       WR_CONV_BANK_OUT,    // write targets converter bank
    output logic [ADDR_W-1:0]          WR_ADDR_OUT,         // written register address
    output logic [DATA_W-1:0]          WR_DATA_OUT          // written control data
);

    // ==========================================================
    // link-side state
    dev_state_t                state_r,   state_nxt;
    logic [3:0]                bit_cnt_r, bit_cnt_nxt;
    logic [DATA_W-1:0]         shift_r,   shift_nxt;
    logic [DATA_W-1:0]         tx_r,      tx_nxt;
    logic [ADDR_W-1:0]         ptr_r,     ptr_nxt;
    logic                      conv_r,    conv_nxt;
    logic                      ack_r,     ack_nxt;
    logic [DATA_W-1:0]         mem_r   [REG_CNT];
    logic [DATA_W-1:0]         mem_nxt [REG_CNT];
    logic                      wr_tgl_r,  wr_tgl_nxt;
    logic                      wr_conv_r, wr_conv_nxt;
    logic [ADDR_W-1:0]         wr_addr_r, wr_addr_nxt;
    logic [DATA_W-1:0]         wr_data_r, wr_data_nxt;
    logic                      seen_r,    seen_nxt;
    logic                      start_tgl_r, start_tgl_nxt;
    logic [1:0]                sel_s1_r,  sel_s2_r;
    logic                      sda_oe_r,  sda_oe_nxt;
    logic                      start_pend;
    logic [DATA_W-1:0]         shifted;
    logic                      match;

    // ==========================================================
    // start detection: data falls while clock high
    assign start_tgl_nxt = LINK_IF.scl ? ~start_tgl_r : start_tgl_r;

    // start toggle, clocked by the falling data line
    always_ff @(negedge LINK_IF.sda or negedge RESET_N_IN) begin
        if (!RESET_N_IN) begin
            start_tgl_r <= 1'b0;
        end else begin
            start_tgl_r <= start_tgl_nxt;
        end
    end

    // the toggle settles at least three quarters of a link clock before the next rising edge
    assign start_pend = start_tgl_r != seen_r;
    assign shifted    = {shift_r[DATA_W-2:0], LINK_IF.sda};

    // address match on the completed first byte
    always_comb begin
        match = (shifted[7:3] == SLAVE_PREFIX) &&
                ((shifted[2:1] == RXTX_BANK_SEL) ||
                 ((shifted[2:1] == sel_s2_r) && (sel_s2_r != RXTX_BANK_SEL))) &&
                !((shifted[2:1] != RXTX_BANK_SEL) && shifted[0]);
    end

    // ==========================================================
    // byte sequencer, sampled on rising link clock
    always_comb begin
        state_nxt   = state_r;
        bit_cnt_nxt = bit_cnt_r;
        shift_nxt   = shift_r;
        tx_nxt      = tx_r;
        ptr_nxt     = ptr_r;
        conv_nxt    = conv_r;
        ack_nxt     = ack_r;
        mem_nxt     = mem_r;
        wr_tgl_nxt  = wr_tgl_r;
        wr_conv_nxt = wr_conv_r;
        wr_addr_nxt = wr_addr_r;
        wr_data_nxt = wr_data_r;
        seen_nxt    = start_tgl_r;
        if (start_pend) begin
            // first address bit arrives on the edge after start
            state_nxt   = D_SLAVE;
            shift_nxt   = shifted;
            bit_cnt_nxt = 4'h1;
            ack_nxt     = 1'b0;
        end else begin
            case (state_r)
                D_IDLE: begin
                    ack_nxt = 1'b0;
                end
                D_SLAVE, D_REGA, D_WDATA: begin
                    if (bit_cnt_r < BYTE_BITS) begin
                        shift_nxt   = shifted;
                        bit_cnt_nxt = bit_cnt_r + 4'h1;
                        if (bit_cnt_r == LAST_BIT) begin
                            if (state_r == D_SLAVE) begin
                                ack_nxt  = match;
                                conv_nxt = shifted[2:1] != RXTX_BANK_SEL;
                            end else begin
                                ack_nxt = 1'b1;
                            end
                        end
                    end else begin
                        // ack clock of the byte
                        bit_cnt_nxt = 4'h0;
                        ack_nxt     = 1'b0;
                        case (state_r)
                            D_SLAVE: begin
                                if (!ack_r) begin
                                    state_nxt = D_IDLE;
                                end else if (shift_r[0]) begin
                                    state_nxt = D_RDATA;
                                    tx_nxt    = mem_r[ptr_r];
                                end else begin
                                    state_nxt = D_REGA;
                                end
                            end
                            D_REGA: begin
                                ptr_nxt   = shift_r[ADDR_W-1:0];
                                state_nxt = D_WDATA;
                            end
                            default: begin
                                // commit only once the byte is acknowledged
                                if (!conv_r) begin
                                    mem_nxt[ptr_r] = shift_r;
                                end
                                wr_conv_nxt = conv_r;
                                wr_addr_nxt = ptr_r;
                                wr_data_nxt = shift_r;
                                wr_tgl_nxt  = ~wr_tgl_r;
                                ptr_nxt     = next_ptr(ptr_r);
                            end
                        endcase
                    end
                end
                D_RDATA: begin
                    if (bit_cnt_r < BYTE_BITS) begin
                        bit_cnt_nxt = bit_cnt_r + 4'h1;
                    end else begin
                        bit_cnt_nxt = 4'h0;
                        ptr_nxt     = next_ptr(ptr_r);
                        if (!LINK_IF.sda) begin
                            tx_nxt = mem_r[next_ptr(ptr_r)];
                        end else begin
                            state_nxt = D_IDLE;
                        end
                    end
                end
                default: begin
                    state_nxt = D_IDLE;
                end
            endcase
        end
    end

    // register the sequencer
    always_ff @(posedge LINK_IF.scl or negedge RESET_N_IN) begin
        if (!RESET_N_IN) begin
            state_r   <= D_IDLE;
            bit_cnt_r <= 4'h0;
            shift_r   <= REG_RESET;
            tx_r      <= REG_RESET;
            ptr_r     <= PTR_RESET;
            conv_r    <= 1'b0;
            ack_r     <= 1'b0;
            wr_tgl_r  <= 1'b0;
            wr_conv_r <= 1'b0;
            wr_addr_r <= PTR_RESET;
            wr_data_r <= REG_RESET;
            seen_r    <= 1'b0;
            for (int i = 0; i < REG_CNT; i++) begin
                mem_r[i] <= REG_RESET;
            end
        end else begin
            state_r   <= state_nxt;
            bit_cnt_r <= bit_cnt_nxt;
            shift_r   <= shift_nxt;
            tx_r      <= tx_nxt;
            ptr_r     <= ptr_nxt;
            conv_r    <= conv_nxt;
            ack_r     <= ack_nxt;
            wr_tgl_r  <= wr_tgl_nxt;
            wr_conv_r <= wr_conv_nxt;
            wr_addr_r <= wr_addr_nxt;
            wr_data_r <= wr_data_nxt;
            seen_r    <= seen_nxt;
            mem_r     <= mem_nxt;
        end
    end

    // strap pins cross into the link domain through two flops
    always_ff @(posedge LINK_IF.scl or negedge RESET_N_IN) begin
        if (!RESET_N_IN) begin
            sel_s1_r <= 2'h0;
            sel_s2_r <= 2'h0;
        end else begin
            sel_s1_r <= {ADDR_SELECT_PIN_HI_IN, ADDR_SELECT_PIN_LO_IN};
            sel_s2_r <= sel_s1_r;
        end
    end

    // ==========================================================
    // data drive, changed on falling link clock
    always_comb begin
        if ((state_r == D_RDATA) && (bit_cnt_r < BYTE_BITS)) begin
            sda_oe_nxt = ~tx_r[~bit_cnt_r[2:0]];
        end else begin
            sda_oe_nxt = ack_r && (bit_cnt_r == BYTE_BITS);
        end
    end

    // register the data drive
    always_ff @(negedge LINK_IF.scl or negedge RESET_N_IN) begin
        if (!RESET_N_IN) begin
            sda_oe_r <= 1'b0;
        end else begin
            sda_oe_r <= sda_oe_nxt;
        end
    end

    assign LINK_IF.s_sda_oe  = sda_oe_r;
    assign LINK_IF.s_sda_out = 1'b0;

    // ==========================================================
    // write hand-off into the system domain by toggle
    logic wr_s1_r, wr_s2_r, wr_s3_r;
    logic stb_nxt;

    assign stb_nxt = wr_s2_r != wr_s3_r;

    // sync and capture; held data is stable for a whole byte time
    always_ff @(posedge SYS_CLK_IN or negedge RESET_N_IN) begin
        if (!RESET_N_IN) begin
            wr_s1_r          <= 1'b0;
            wr_s2_r          <= 1'b0;
            wr_s3_r          <= 1'b0;
            WR_STB_OUT       <= 1'b0;
            WR_CONV_BANK_OUT <= 1'b0;
            WR_ADDR_OUT      <= PTR_RESET;
            WR_DATA_OUT      <= REG_RESET;
        end else begin
            wr_s1_r    <= wr_tgl_r;
            wr_s2_r    <= wr_s1_r;
            wr_s3_r    <= wr_s2_r;
            WR_STB_OUT <= stb_nxt;
            if (stb_nxt) begin
                WR_CONV_BANK_OUT <= wr_conv_r;
                WR_ADDR_OUT      <= wr_addr_r;
                WR_DATA_OUT      <= wr_data_r;
            end
        end
    end

endmodule // i2c_codec_device

// ==== i2c_codec_host.sv ====
// host end: byte-level two-wire master with a divided link clock
`timescale 1ns/1ps
module i2c_codec_host
    import i2c_codec_pkg::*;
(
    input  wire logic          SYS_CLK_IN,      // system clock, 10 MHz
    input  wire logic          RESET_N_IN,      // reset, active low
    i2c_codec_link_if.host     LINK_IF,         // two-wire link
    input  wire logic          CMD_VALID_IN,    // operation request
    output logic               CMD_READY_OUT,   // sequencer idle
    input  wire op_t           CMD_OP_IN,       // start, write, read or stop
    input  wire logic [7:0]    CMD_DATA_IN,     // byte to write
    input  wire logic          CMD_ACK_IN,      // acknowledge a read byte
    output logic               DONE_OUT,        // one-cycle completion pulse
    output logic [7:0]         RD_DATA_OUT,     // byte read
    output logic               ACK_SEEN_OUT     // ninth bit was low
);

    host_state_t     state_r, state_nxt;
    logic [4:0]      div_r,   div_nxt;
    logic [1:0]      q_r,     q_nxt;
    logic [3:0]      bit_r,   bit_nxt;
    logic [8:0]      sh_r,    sh_nxt;
    logic [8:0]      rx_r,    rx_nxt;
    logic            scl_r,   scl_nxt;
    logic            oe_r,    oe_nxt;
    logic            done_nxt;
    logic [7:0]      rd_nxt;
    logic            ackd_nxt;
    logic            sda_s1_r, sda_s2_r;
    logic            tick;

    assign tick          = div_r == QTR_LAST;
    assign CMD_READY_OUT = state_r == M_IDLE;

    // ==========================================================
    // quarter-period sequencer; clock divided for 100 kHz
    always_comb begin
        state_nxt = state_r;
        div_nxt   = tick ? 5'h00 : div_r + 5'h01;
        q_nxt     = tick ? q_r + 2'h1 : q_r;
        bit_nxt   = bit_r;
        sh_nxt    = sh_r;
        rx_nxt    = rx_r;
        scl_nxt   = scl_r;
        oe_nxt    = oe_r;
        done_nxt  = 1'b0;
        rd_nxt    = RD_DATA_OUT;
        ackd_nxt  = ACK_SEEN_OUT;
        case (state_r)
            M_IDLE: begin
                div_nxt = 5'h00;
                q_nxt   = 2'h0;
                bit_nxt = 4'h0;
                if (CMD_VALID_IN) begin
                    case (CMD_OP_IN)
                        OP_START: state_nxt = M_START;
                        OP_STOP:  state_nxt = M_STOP;
                        OP_WRITE: begin
                            state_nxt = M_BIT;
                            sh_nxt    = {CMD_DATA_IN, 1'b1};
                        end
                        default: begin
                            state_nxt = M_BIT;
                            sh_nxt    = {8'hFF, ~CMD_ACK_IN};
                        end
                    endcase
                end
            end
            M_START: begin
                if (tick) begin
                    case (q_r)
                        2'h0: oe_nxt = 1'b0;
                        2'h1: scl_nxt = 1'b1;
                        2'h2: oe_nxt = 1'b1;
                        default: begin
                            scl_nxt   = 1'b0;
                            done_nxt  = 1'b1;
                            state_nxt = M_IDLE;
                        end
                    endcase
                end
            end
            M_BIT: begin
                if (tick) begin
                    case (q_r)
                        2'h0: oe_nxt = ~sh_r[8];
                        2'h1: scl_nxt = 1'b1;
                        2'h2: rx_nxt = {rx_r[7:0], sda_s2_r};
                        default: begin
                            scl_nxt = 1'b0;
                            sh_nxt  = {sh_r[7:0], 1'b1};
                            bit_nxt = bit_r + 4'h1;
                            if (bit_r == BYTE_BITS) begin
                                oe_nxt    = 1'b0;
                                done_nxt  = 1'b1;
                                rd_nxt    = rx_r[8:1];
                                ackd_nxt  = ~rx_r[0];
                                state_nxt = M_IDLE;
                            end
                        end
                    endcase
                end
            end
            M_STOP: begin
                if (tick) begin
                    case (q_r)
                        2'h0: oe_nxt = 1'b1;
                        2'h1: scl_nxt = 1'b1;
                        2'h2: oe_nxt = 1'b0;
                        default: begin
                            done_nxt  = 1'b1;
                            state_nxt = M_IDLE;
                        end
                    endcase
                end
            end
            default: begin
                state_nxt = M_IDLE;
            end
        endcase
    end

    // register the sequencer; data line passes two flops
    always_ff @(posedge SYS_CLK_IN or negedge RESET_N_IN) begin
        if (!RESET_N_IN) begin
            state_r      <= M_IDLE;
            div_r        <= 5'h00;
            q_r          <= 2'h0;
            bit_r        <= 4'h0;
            sh_r         <= 9'h1FF;
            rx_r         <= 9'h000;
            scl_r        <= 1'b1;
            oe_r         <= 1'b0;
            DONE_OUT     <= 1'b0;
            RD_DATA_OUT  <= 8'h00;
            ACK_SEEN_OUT <= 1'b0;
            sda_s1_r     <= 1'b1;
            sda_s2_r     <= 1'b1;
        end else begin
            state_r      <= state_nxt;
            div_r        <= div_nxt;
            q_r          <= q_nxt;
            bit_r        <= bit_nxt;
            sh_r         <= sh_nxt;
            rx_r         <= rx_nxt;
            scl_r        <= scl_nxt;
            oe_r         <= oe_nxt;
            DONE_OUT     <= done_nxt;
            RD_DATA_OUT  <= rd_nxt;
            ACK_SEEN_OUT <= ackd_nxt;
            sda_s1_r     <= LINK_IF.sda;
            sda_s2_r     <= sda_s1_r;
        end
    end

    assign LINK_IF.scl       = scl_r;
    assign LINK_IF.m_sda_oe  = oe_r;
    assign LINK_IF.m_sda_out = 1'b0;

endmodule // i2c_codec_host

// ==== i2c_codec_link_sva.sv ====
// concurrent checks on the two-wire link between host and control port
`timescale 1ns/1ps
module i2c_codec_link_sva
    import i2c_codec_pkg::*;
(
    input wire logic SYS_CLK_IN, // system clock
    input wire logic RESET_N_IN, // reset, active low
    input wire logic scl,        // link clock
    input wire logic m_sda_oe,   // host pulls data low
    input wire logic s_sda_oe,   // device pulls data low
    input wire logic sda         // resolved data line
);
    // ====================
    // cycles spent at the present link clock level
    logic       scl_r;
    logic [7:0] ph_r;
    logic [7:0] ph_nxt;
    // restart on a level change, saturate otherwise
    always_comb begin
        ph_nxt = (scl != scl_r) ? 8'h00 : ph_r + {7'h00, ~&ph_r};
    end
    // register the level and the count
    always_ff @(posedge SYS_CLK_IN or negedge RESET_N_IN) begin
        if (!RESET_N_IN) begin
            scl_r <= 1'b1;
            ph_r  <= 8'hFF;
        end else begin
            scl_r <= scl;
            ph_r  <= ph_nxt;
        end
    end
    // ====================
    // link timing and line ownership
    default clocking @(posedge SYS_CLK_IN); endclocking
    default disable iff (!RESET_N_IN);
    sequence start_seq; scl && $rose(m_sda_oe); endsequence
    sequence stop_seq; scl && $fell(m_sda_oe); endsequence
    sequence ack_seq; $rose(s_sda_oe) && !scl; endsequence
    chk_scl_high_time: assert property ($fell(scl) |-> ph_r >= SCL_HI_MIN)
        else $error("link clock high phase too short");
    chk_scl_low_time: assert property ($rose(scl) |-> ph_r >= SCL_LO_MIN)
        else $error("link clock low phase too short");
    chk_dev_low_edge: assert property ($changed(s_sda_oe) |-> !scl)
        else $error("device changed data while clock high");
    chk_start_hold: assert property (start_seq |=> (scl && !sda)[*8])
        else $error("start condition not held");
    chk_stop_release: assert property (stop_seq |-> (sda && !s_sda_oe)[*8])
        else $error("data line not released after stop");
    chk_ack_hold: assert property (ack_seq |-> (s_sda_oe && !scl)[*8])
        else $error("device pull not held through clock low");
    chk_high_hold: assert property (s_sda_oe && $rose(scl) |-> s_sda_oe[*8])
        else $error("device pull dropped while clock high");
    chk_start_by_host: assert property ($fell(sda) && scl |-> m_sda_oe)
        else $error("data fell under high clock without host");
endmodule // i2c_codec_link_sva

// ==== test_codec_i2c_register_slave.sv ====
// bench: host end and codec control port joined over the two-wire link
`timescale 1ns/1ps
module test_codec_i2c_register_slave
    import i2c_codec_pkg::*;
;
    // ====================
    // stimulus and observed signals
    logic        clk;
    logic        rst_n;
    logic        valid;
    op_t         op;
    logic [7:0]  dat;
    logic        ack;
    logic        ready;
    logic        done;
    logic [7:0]  rd;
    logic        ack_seen;
    logic        wr_stb;
    logic        wr_conv;
    logic [4:0]  wr_addr;
    logic [7:0]  wr_data;
    logic [13:0] wq[$];
    int          n_errors;
    int          n_compared;
    logic [7:0]  bad[4] = '{8'h30, 8'h23, 8'h24, 8'h26};

    i2c_codec_link_if i2c_codec_link_if_i ();
    i2c_codec_host i2c_codec_host_i (.SYS_CLK_IN(clk), .RESET_N_IN(rst_n),
        .LINK_IF(i2c_codec_link_if_i), .CMD_VALID_IN(valid), .CMD_READY_OUT(ready),
        .CMD_OP_IN(op), .CMD_DATA_IN(dat), .CMD_ACK_IN(ack), .DONE_OUT(done),
        .RD_DATA_OUT(rd), .ACK_SEEN_OUT(ack_seen));
    i2c_codec_device i2c_codec_device_i (.SYS_CLK_IN(clk), .RESET_N_IN(rst_n),
        .LINK_IF(i2c_codec_link_if_i), .ADDR_SELECT_PIN_HI_IN(1'b0),
        .ADDR_SELECT_PIN_LO_IN(1'b1), .WR_STB_OUT(wr_stb), .WR_CONV_BANK_OUT(wr_conv),
        .WR_ADDR_OUT(wr_addr), .WR_DATA_OUT(wr_data));
    i2c_codec_link_sva i2c_codec_link_sva_i (.SYS_CLK_IN(clk), .RESET_N_IN(rst_n),
        .scl(i2c_codec_link_if_i.scl), .m_sda_oe(i2c_codec_link_if_i.m_sda_oe),
        .s_sda_oe(i2c_codec_link_if_i.s_sda_oe), .sda(i2c_codec_link_if_i.sda));

    // ====================
    // tasks: one host operation, byte helpers, compare, verdict
    task automatic cmd(input op_t o, input logic [7:0] d, input logic a);
        int n;
        valid <= 1'b1;
        op <= o;
        dat <= d;
        ack <= a;
        n = 0;
        do begin @(posedge clk); n++; end while (ready !== 1'b1 && n < 3000);
        valid <= 1'b0;
        do begin @(posedge clk); n++; end while (done !== 1'b1 && n < 3000);
        // a command that never completes counts against the run
        if (n >= 3000) begin
            n_errors++;
            $display("mismatch at %0t: command never completed", $time);
        end
    endtask
    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        n_compared++;
        if (got !== exp) begin
            n_errors++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic st(input op_t o);
        cmd(o, 8'h00, 1'b0);
    endtask
    task automatic wb(input logic [7:0] b, input logic a);
        cmd(OP_WRITE, b, 1'b0);
        check(16'(ack_seen), 16'(a));
    endtask
    task automatic rb(input logic a, input logic [7:0] e);
        cmd(OP_READ, 8'h00, a);
        check(16'(rd), 16'(e));
    endtask
    task automatic wchk(input logic [13:0] e);
        check(wq.size() > 0 ? 16'(wq.pop_front()) : 16'hFFFF, 16'(e));
    endtask
    task automatic complete_run();
        $display("compared %0d, mismatches %0d", n_compared, n_errors);
        if (n_errors == 0 && n_compared > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask

    // collect each committed write as bank, address, data
    always @(posedge clk) begin
        if (wr_stb === 1'b1) wq.push_back({wr_conv, wr_addr, wr_data});
    end
    // system clock, 100 ns period
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    // cut a hang short
    initial begin
        repeat (40000) @(posedge clk);
        n_errors++;
        $display("mismatch at %0t: timeout", $time);
        complete_run();
    end
    // reset, then the transfer tests
    initial begin
        rst_n <= 1'b0; // scheduled late so every reset process sees the edge
        valid = 1'b0;
        op = OP_START;
        dat = 8'h00;
        ack = 1'b0;
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        st(OP_START);
        wb(8'h22, 1'b1);
        wb(8'hFF, 1'b1);
        wb(8'hA5, 1'b1);
        wb(8'h3C, 1'b1);
        st(OP_STOP);
        wchk({1'b1, 5'h1F, 8'hA5});
        wchk({1'b1, 5'h00, 8'h3C});
        $display("test converter write with wrap done");
        st(OP_START);
        wb(8'h20, 1'b1);
        wb(8'h03, 1'b1);
        wb(8'h11, 1'b1);
        wb(8'h22, 1'b1);
        wb(8'h33, 1'b1);
        st(OP_STOP);
        wchk({1'b0, 5'h03, 8'h11});
        wchk({1'b0, 5'h04, 8'h22});
        wchk({1'b0, 5'h05, 8'h33});
        $display("test rx/tx write done");
        st(OP_START);
        wb(8'h20, 1'b1);
        wb(8'h03, 1'b1);
        st(OP_START);
        wb(8'h21, 1'b1);
        rb(1'b1, 8'h11);
        rb(1'b0, 8'h22);
        st(OP_STOP);
        st(OP_START);
        wb(8'h21, 1'b1);
        rb(1'b0, 8'h33);
        st(OP_STOP);
        $display("test random and current reads done");
        foreach (bad[i]) begin
            st(OP_START);
            wb(bad[i], 1'b0);
            wb(8'h07, 1'b0);
            st(OP_STOP);
        end
        check(16'(wq.size()), 16'h0000);
        $display("test refused addresses done");
        complete_run();
    end
endmodule // test_codec_i2c_register_slave
